//--- pkg/saso_pkg.sv
// constants shared by the stereo converter serial back end
//
// Contract
// - format_select low gives I2S output, high gives left-justified output.
// - highpass_bypass low runs the high-pass filter, high bypasses it.
// - undriven mode pins read low: I2S with high-pass filter enabled.
// - master clock of 256, 384, 512 or 768 fs runs the decimators.
// - every channel word on serial_sample_out is 24 bits.
// - sample rate from 8 kHz to 96 kHz inclusive works.
// - two independent channels, one output sample each per sample period.
// - decimation uses full 24-bit arithmetic, one sample per frame period.
// - data changes after bit clock falling edges; frame clock stable at rising.
// - left-justified: MSB on frame change edge, frame high means left.
// - I2S: MSB one falling edge after frame change, frame low means left.
// - auto-detect clock ratio; beyond 32 clocks off, disable and hold last sample.
// - enabled high-pass is (1 - z^-1)/(1 - 0.9995 z^-1) per channel.
package saso_pkg;
  localparam int SAMPLE_W = 24;
  localparam int MOD_W = 4;
  localparam int DEC_SHIFT = 10;
  localparam int HP_SHIFT = 11;
  localparam int MCLK_CNT_W = 11;
  localparam int BIT_CNT_W = 9;
  localparam int RATIO_TOL = 32;
  localparam int NUM_RATIOS = 4;
  localparam logic [MCLK_CNT_W-1:0] RATIO_256 = 11'h100;
  localparam logic [MCLK_CNT_W-1:0] RATIO_384 = 11'h180;
  localparam logic [MCLK_CNT_W-1:0] RATIO_512 = 11'h200;
  localparam logic [MCLK_CNT_W-1:0] RATIO_768 = 11'h300;
  localparam int FS_MIN_HZ = 8000;
  localparam int FS_MAX_HZ = 96000;
  localparam int BUF_DEPTH = 2;
  localparam logic SDATA_RESET = 1'b0;
  localparam logic MODE_PIN_RESET = 1'b0;
endpackage

//--- rtl/saso_highpass.sv
// one-channel dc-removing high-pass stage with bypass and handshake
`timescale 1ns/10ps
module saso_highpass #(
  parameter int W = saso_pkg::SAMPLE_W,
  parameter int SHIFT = saso_pkg::HP_SHIFT
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic bypass,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic signed [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic signed [W-1:0] out_data
);
  localparam logic signed [W+1:0] SAT_MAX = (W+2)'((1 <<< (W-1)) - 1);
  localparam logic signed [W+1:0] SAT_MIN = -(W+2)'(1 <<< (W-1));

  logic signed [W-1:0] x_prev_reg;
  logic signed [W-1:0] y_reg;
  logic signed [W+1:0] y_wide;
  logic signed [W-1:0] y_next;

  assign in_ready = !out_valid || out_ready;

  // y = x - x_prev + y * (1 - 2^-11), pole 0.99951
  always_comb
  begin
    y_wide = (W+2)'(in_data) - (W+2)'(x_prev_reg) + (W+2)'(y_reg)
      - (W+2)'(y_reg >>> SHIFT);
    if (y_wide > SAT_MAX)
    begin
      y_next = SAT_MAX[W-1:0];
    end
    else if (y_wide < SAT_MIN)
    begin
      y_next = SAT_MIN[W-1:0];
    end
    else
    begin
      y_next = y_wide[W-1:0];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      x_prev_reg <= '0;
      y_reg <= '0;
    end
    else if (in_valid && in_ready)
    begin
      x_prev_reg <= in_data;
      y_reg <= y_next;
    end
  end

  // both paths leave through the same register: equal latency
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      out_valid <= 1'b0;
      out_data <= '0;
    end
    else if (in_valid && in_ready)
    begin
      out_valid <= 1'b1;
      out_data <= bypass ? in_data : y_next;
    end
    else if (out_ready)
    begin
      out_valid <= 1'b0;
    end
  end
endmodule

//--- rtl/saso_top.sv
// stereo converter back end: decimation, high-pass, serial output
`timescale 1ns/10ps
module saso_top #(
  parameter int SAMPLE_W = saso_pkg::SAMPLE_W,
  parameter int MOD_W = saso_pkg::MOD_W,
  parameter int DEPTH = saso_pkg::BUF_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic master_clock,
  input wire logic serial_bit_clock,
  input wire logic channel_frame_clock,
  input wire logic format_select,
  input wire logic highpass_bypass,
  input wire logic signed [MOD_W-1:0] left_analog_in,
  input wire logic signed [MOD_W-1:0] right_analog_in,
  output logic serial_sample_out
);
  localparam int PW = 2 * SAMPLE_W;
  localparam int CW = saso_pkg::MCLK_CNT_W;
  localparam int BW = saso_pkg::BIT_CNT_W;
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic signed [SAMPLE_W-1:0] ACC_MAX = {1'b0, {(SAMPLE_W-1){1'b1}}};
  localparam logic signed [SAMPLE_W-1:0] ACC_MIN = {1'b1, {(SAMPLE_W-1){1'b0}}};
  localparam logic [CW-1:0] RATIOS [saso_pkg::NUM_RATIOS] = '{saso_pkg::RATIO_256,
    saso_pkg::RATIO_384, saso_pkg::RATIO_512, saso_pkg::RATIO_768};

  // pin synchronisers, system side
  logic mclk_s1_reg, mclk_s2_reg, mclk_s3_reg;
  logic frame_s1_reg, frame_s2_reg, frame_s3_reg;
  logic fmt_s1_reg, fmt_s2_reg;
  logic hpb_s1_reg, hpb_s2_reg;
  logic signed [MOD_W-1:0] mod_l_s1_reg, mod_l_s2_reg;
  logic signed [MOD_W-1:0] mod_r_s1_reg, mod_r_s2_reg;
  logic mclk_rise, frame_rise;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      mclk_s1_reg <= 1'b0;
      mclk_s2_reg <= 1'b0;
      mclk_s3_reg <= 1'b0;
      frame_s1_reg <= 1'b0;
      frame_s2_reg <= 1'b0;
      frame_s3_reg <= 1'b0;
      fmt_s1_reg <= saso_pkg::MODE_PIN_RESET;
      fmt_s2_reg <= saso_pkg::MODE_PIN_RESET;
      hpb_s1_reg <= saso_pkg::MODE_PIN_RESET;
      hpb_s2_reg <= saso_pkg::MODE_PIN_RESET;
      mod_l_s1_reg <= '0;
      mod_l_s2_reg <= '0;
      mod_r_s1_reg <= '0;
      mod_r_s2_reg <= '0;
    end
    else
    begin
      mclk_s1_reg <= master_clock;
      mclk_s2_reg <= mclk_s1_reg;
      mclk_s3_reg <= mclk_s2_reg;
      frame_s1_reg <= channel_frame_clock;
      frame_s2_reg <= frame_s1_reg;
      frame_s3_reg <= frame_s2_reg;
      fmt_s1_reg <= format_select;
      fmt_s2_reg <= fmt_s1_reg;
      hpb_s1_reg <= highpass_bypass;
      hpb_s2_reg <= hpb_s1_reg;
      mod_l_s1_reg <= left_analog_in;
      mod_l_s2_reg <= mod_l_s1_reg;
      mod_r_s1_reg <= right_analog_in;
      mod_r_s2_reg <= mod_r_s1_reg;
    end
  end

  assign mclk_rise = mclk_s2_reg && !mclk_s3_reg;
  assign frame_rise = frame_s2_reg && !frame_s3_reg;

  // clock ratio detection: master clocks per frame period
  logic [CW-1:0] mclk_cnt_reg;
  logic ratio_ok_reg;
  logic [saso_pkg::NUM_RATIOS-1:0] ratio_hit;

  for (genvar i = 0; i < saso_pkg::NUM_RATIOS; i++)
  begin : g_ratio
    assign ratio_hit[i] = (mclk_cnt_reg + CW'(saso_pkg::RATIO_TOL) >= RATIOS[i])
      && (mclk_cnt_reg <= RATIOS[i] + CW'(saso_pkg::RATIO_TOL));
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      mclk_cnt_reg <= '0;
      ratio_ok_reg <= 1'b0;
    end
    else if (frame_rise)
    begin
      mclk_cnt_reg <= CW'(mclk_rise);
      ratio_ok_reg <= |ratio_hit;
    end
    else if (mclk_rise && !(&mclk_cnt_reg))
      mclk_cnt_reg <= mclk_cnt_reg + 1'b1;
  end

  // boxcar decimators, one per channel, one sample each per frame
  logic signed [SAMPLE_W-1:0] acc_reg [2];
  logic signed [SAMPLE_W-1:0] dump_reg [2];
  logic dump_valid_reg;
  logic [1:0] hp_in_ready;
  logic [1:0] hp_out_valid;
  logic signed [SAMPLE_W-1:0] hp_out [2];
  logic fifo_in_ready;

  for (genvar c = 0; c < 2; c++)
  begin : g_chan
    logic signed [MOD_W-1:0] mod_word;
    logic signed [SAMPLE_W:0] acc_sum;
    assign mod_word = (c == 0) ? mod_l_s2_reg : mod_r_s2_reg;
    assign acc_sum = (SAMPLE_W+1)'(acc_reg[c]) + (SAMPLE_W+1)'(mod_word);

    always_ff @(posedge clk_sys)
    begin
      if (rst)
      begin
        acc_reg[c] <= '0;
        dump_reg[c] <= '0;
      end
      else if (frame_rise)
      begin
        acc_reg[c] <= mclk_rise ? SAMPLE_W'(mod_word) : '0;
        dump_reg[c] <= SAMPLE_W'(acc_reg[c] <<< saso_pkg::DEC_SHIFT);
      end
      else if (mclk_rise)
      begin
        if (acc_sum[SAMPLE_W] != acc_sum[SAMPLE_W-1])
          acc_reg[c] <= acc_sum[SAMPLE_W] ? ACC_MIN : ACC_MAX;
        else
          acc_reg[c] <= acc_sum[SAMPLE_W-1:0];
      end
    end

    saso_highpass #(
      .W(SAMPLE_W),
      .SHIFT(saso_pkg::HP_SHIFT)
    ) u_hp (
      .clk_sys(clk_sys),
      .rst(rst),
      .bypass(hpb_s2_reg),
      .in_valid(dump_valid_reg),
      .in_ready(hp_in_ready[c]),
      .in_data(dump_reg[c]),
      .out_valid(hp_out_valid[c]),
      .out_ready(fifo_in_ready),
      .out_data(hp_out[c])
    );
  end

  // a dump waits for the filter stage rather than vanishing
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      dump_valid_reg <= 1'b0;
    else if (frame_rise)
      dump_valid_reg <= 1'b1;
    else if (&hp_in_ready)
      dump_valid_reg <= 1'b0;
  end

  // two-entry pair buffer ahead of the link crossing
  logic [PW-1:0] buf_mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg, rd_ptr_reg;
  logic [AW:0] count_reg;
  logic buf_push, buf_pop, buf_out_valid;
  logic req_reg, ack_s1_reg, ack_s2_reg, ack_reg;
  logic [PW-1:0] xfer_reg;
  logic xfer_idle;

  assign fifo_in_ready = (count_reg != (AW+1)'(DEPTH));
  assign buf_push = (&hp_out_valid) && fifo_in_ready;
  assign buf_out_valid = (count_reg != '0);
  assign xfer_idle = (req_reg == ack_s2_reg);
  assign buf_pop = buf_out_valid && xfer_idle;

  always_ff @(posedge clk_sys)
  begin
    if (buf_push)
      buf_mem[wr_ptr_reg] <= {hp_out[0], hp_out[1]};
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (buf_push)
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      if (buf_pop)
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      count_reg <= count_reg + (AW+1)'(buf_push) - (AW+1)'(buf_pop);
    end
  end

  // toggle handshake: xfer_reg holds still while a request is open
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      req_reg <= 1'b0;
      xfer_reg <= '0;
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
    end
    else
    begin
      ack_s1_reg <= ack_reg;
      ack_s2_reg <= ack_s1_reg;
      if (buf_pop)
      begin
        xfer_reg <= buf_mem[rd_ptr_reg];
        req_reg <= !req_reg;
      end
    end
  end

  // link side, clocked by the bit clock from the interface master
  logic rst_b1_reg, rst_b2_reg;
  logic req_b1_reg, req_b2_reg;
  logic en_b1_reg, en_b2_reg;
  logic fmt_b1_reg, fmt_b2_reg;
  logic lr_pos_reg, lr_prev_reg, lj_early_reg;
  logic [BW-1:0] bit_cnt_reg, half_len_reg;
  logic [PW-1:0] pair_reg;
  logic [SAMPLE_W-1:0] shift_reg;
  logic [4:0] bits_left_reg;
  logic lr_change, lj_predict, start, start_left, take_new;
  logic [SAMPLE_W-1:0] start_word;

  // frame clock is stable at the rising edge, so one capture there suffices
  always_ff @(posedge serial_bit_clock)
  begin
    lr_pos_reg <= channel_frame_clock;
  end

  always_ff @(negedge serial_bit_clock)
  begin
    rst_b1_reg <= rst;
    rst_b2_reg <= rst_b1_reg;
    req_b1_reg <= req_reg;
    req_b2_reg <= req_b1_reg;
    en_b1_reg <= ratio_ok_reg;
    en_b2_reg <= en_b1_reg;
    fmt_b1_reg <= fmt_s2_reg;
    fmt_b2_reg <= fmt_b1_reg;
  end

  assign lr_change = (lr_pos_reg != lr_prev_reg);
  assign lj_predict = fmt_b2_reg && (half_len_reg != '0)
    && (bit_cnt_reg == half_len_reg - 1'b1);
  always_comb
  begin
    start = 1'b0;
    start_left = 1'b0;
    if (!fmt_b2_reg)
    begin
      start = lr_change;
      start_left = !lr_pos_reg;
    end
    else if (lj_predict || (lr_change && !lj_early_reg))
    begin
      start = 1'b1;
      start_left = lj_predict ? !lr_pos_reg : lr_pos_reg;
    end
  end

  assign take_new = start && start_left && (req_b2_reg != ack_reg);
  always_comb
  begin
    start_word = pair_reg[SAMPLE_W-1:0];
    if (take_new && en_b2_reg)
      start_word = xfer_reg[PW-1:SAMPLE_W];
    else if (start_left)
      start_word = pair_reg[PW-1:SAMPLE_W];
  end

  always_ff @(negedge serial_bit_clock)
  begin
    if (rst_b2_reg)
    begin
      lr_prev_reg <= 1'b0;
      lj_early_reg <= 1'b0;
      bit_cnt_reg <= '0;
      half_len_reg <= '0;
    end
    else
    begin
      lr_prev_reg <= lr_pos_reg;
      if (lr_change)
      begin
        half_len_reg <= bit_cnt_reg;
        bit_cnt_reg <= BW'(1);
        lj_early_reg <= 1'b0;
      end
      else
      begin
        bit_cnt_reg <= (&bit_cnt_reg) ? bit_cnt_reg : bit_cnt_reg + 1'b1;
        if (lj_predict)
          lj_early_reg <= 1'b1;
      end
    end
  end

  // without a fresh pair, or while disabled, the last pair is repeated
  // pairs offered while disabled are still acknowledged and dropped, so the
  // queue ahead of the crossing cannot grow and latency stays fixed
  always_ff @(negedge serial_bit_clock)
  begin
    if (rst_b2_reg)
    begin
      ack_reg <= 1'b0;
      pair_reg <= '0;
    end
    else if (take_new)
    begin
      ack_reg <= req_b2_reg;
      if (en_b2_reg)
        pair_reg <= xfer_reg;
    end
  end

  always_ff @(negedge serial_bit_clock)
  begin
    if (rst_b2_reg)
    begin
      shift_reg <= '0;
      bits_left_reg <= '0;
      serial_sample_out <= saso_pkg::SDATA_RESET;
    end
    else if (start)
    begin
      serial_sample_out <= start_word[SAMPLE_W-1];
      shift_reg <= start_word << 1;
      bits_left_reg <= 5'(SAMPLE_W - 1);
    end
    else if (bits_left_reg != '0)
    begin
      serial_sample_out <= shift_reg[SAMPLE_W-1];
      shift_reg <= shift_reg << 1;
      bits_left_reg <= bits_left_reg - 1'b1;
    end
    else
      serial_sample_out <= 1'b0;
  end
endmodule

//--- bench/saso_checker.sv
// protocol checker for the serial data line, bound to saso_top
`timescale 1ns/10ps
module saso_checker #(
  parameter int SAMPLE_W = 24,
  parameter int MOD_W = 4,
  parameter int DEPTH = 2
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic master_clock,
  input wire logic serial_bit_clock,
  input wire logic channel_frame_clock,
  input wire logic format_select,
  input wire logic highpass_bypass,
  input wire logic signed [MOD_W-1:0] left_analog_in,
  input wire logic signed [MOD_W-1:0] right_analog_in,
  input wire logic serial_sample_out
);
  logic frame_q;
  logic mode_q;
  logic pos_q;
  logic [7:0] idx_reg;
  logic [7:0] idx_now;
  logic [8:0] age_reg;
  logic lj_ok;
  logic i2s_ok;
  assign idx_now = (channel_frame_clock != frame_q) ? 8'h0 : idx_reg + 8'h1;
  // layout is only judged once the format pin has been steady for two frames
  assign lj_ok = (age_reg > 9'h100) && format_select;
  assign i2s_ok = (age_reg > 9'h100) && !format_select;
  always_ff @(posedge serial_bit_clock)
  begin
    frame_q <= channel_frame_clock;
    idx_reg <= idx_now;
    pos_q <= serial_sample_out;
  end
  always_ff @(posedge serial_bit_clock)
  begin
    mode_q <= format_select;
    if (rst || format_select != mode_q)
      age_reg <= 9'h0;
    else if (age_reg != 9'h1ff)
      age_reg <= age_reg + 9'h1;
  end
  AST_DATA_FALL:
  assert property (@(negedge serial_bit_clock) disable iff (rst) serial_sample_out == pos_q)
    else $error("data moved on a rising bit clock edge");
  AST_LJ_PAD:
  assert property (@(posedge serial_bit_clock) disable iff (rst)
    lj_ok && idx_now >= 8'h18 |-> !serial_sample_out) else $error("pad bit high");
  AST_LJ_TAIL:
  assert property (@(posedge serial_bit_clock) disable iff (rst)
    lj_ok && idx_now == 8'h17 |=> !serial_sample_out [*8]) else $error("word too long");
  AST_I2S_LEAD:
  assert property (@(posedge serial_bit_clock) disable iff (rst)
    i2s_ok && $changed(channel_frame_clock) |-> !serial_sample_out) else $error("early msb");
  AST_I2S_PAD:
  assert property (@(posedge serial_bit_clock) disable iff (rst)
    i2s_ok && idx_now > 8'h18 |-> !serial_sample_out) else $error("pad bit high");
  AST_I2S_TAIL:
  assert property (@(posedge serial_bit_clock) disable iff (rst)
    i2s_ok && idx_now == 8'h19 |-> !serial_sample_out [*8]) else $error("word too long");
  AST_RST_QUIET:
  assert property (@(posedge clk_sys) disable iff (rst)
    $fell(rst) |-> !serial_sample_out [*8]) else $error("data right after reset");
  AST_RST_LINK:
  assert property (@(posedge serial_bit_clock) disable iff (rst)
    $fell(rst) |-> !serial_sample_out) else $error("data at reset release");
  cover property (@(posedge serial_bit_clock) lj_ok && idx_now == 8'h0 && serial_sample_out);
  cover property (@(posedge serial_bit_clock) i2s_ok && idx_now == 8'h1 && serial_sample_out);
  cover property (@(posedge clk_sys) $fell(rst));
endmodule

bind saso_top saso_checker #(.SAMPLE_W(SAMPLE_W), .MOD_W(MOD_W), .DEPTH(DEPTH)) saso_checker_inst (
  .clk_sys(clk_sys),
  .rst(rst),
  .master_clock(master_clock),
  .serial_bit_clock(serial_bit_clock),
  .channel_frame_clock(channel_frame_clock),
  .format_select(format_select),
  .highpass_bypass(highpass_bypass),
  .left_analog_in(left_analog_in),
  .right_analog_in(right_analog_in),
  .serial_sample_out(serial_sample_out)
);

//--- bench/saso_audio_master.sv
// audio interface master model: makes the clocks and captures the words
`timescale 1ns/10ps
module saso_audio_master (
  input wire logic lj_mode,
  input int m_half,
  input wire logic sdo,
  output logic mclk,
  output logic bclk,
  output logic frame,
  output logic [23:0] left_word,
  output logic [23:0] right_word,
  output int frames,
  output int pad_errs
);
  int cnt;
  int idx;
  int pos;
  int mh;
  logic frame_q;
  logic [23:0] sh;
  initial
  begin
    mclk = 1'b0;
    bclk = 1'b0;
    frame = 1'b0;
    frame_q = 1'b0;
    cnt = 0;
    idx = 0;
    frames = 0;
    pad_errs = 0;
    #3.3;
    forever
    begin
      // m_half master clock edges per bit period keep the ratio exact
      // the ratio is latched per bit so a change never drops a bit clock pulse
      mh = m_half;
      for (int i = 0; i < mh; i++)
      begin
        #(125.0 / mh);
        mclk = ~mclk;
        if (i == mh / 2 - 1)
          bclk = 1'b1;
      end
      bclk = 1'b0;
      cnt = (cnt + 1) % 64;
      if (cnt == 0)
        frame = ~frame;
    end
  end
  always @(posedge bclk)
  begin
    idx = (frame != frame_q) ? 0 : idx + 1;
    frame_q = frame;
    pos = lj_mode ? idx : idx - 1;
    if (pos >= 0 && pos < 24)
      sh = {sh[22:0], sdo};
    else if (sdo !== 1'b0)
      pad_errs++;
    if (pos == 23 && frame == lj_mode)
      left_word = sh;
    if (pos == 23 && frame != lj_mode)
    begin
      right_word = sh;
      frames++;
    end
  end
endmodule

//--- bench/tb_saso_top.sv
// self-checking bench for the stereo serial back end
`timescale 1ns/10ps
module tb_saso_top;
  logic clk_sys;
  logic rst;
  logic format_select;
  logic highpass_bypass;
  logic signed [saso_pkg::MOD_W-1:0] left_analog_in;
  logic signed [saso_pkg::MOD_W-1:0] right_analog_in;
  logic signed [saso_pkg::MOD_W-1:0] lv;
  logic signed [saso_pkg::MOD_W-1:0] rv;
  logic mclk;
  logic bclk;
  logic frame;
  logic sdo;
  logic [23:0] left_word;
  logic [23:0] right_word;
  logic [23:0] w1l;
  logic [23:0] w1r;
  int frames;
  int pad_errs;
  int m_half;
  int bad_count;
  int n_checks;
  int p0;
  int seed;
  int ms[4] = '{4, 6, 8, 12};
  saso_top saso_top_inst (
    .clk_sys(clk_sys),
    .rst(rst),
    .master_clock(mclk),
    .serial_bit_clock(bclk),
    .channel_frame_clock(frame),
    .format_select(format_select),
    .highpass_bypass(highpass_bypass),
    .left_analog_in(left_analog_in),
    .right_analog_in(right_analog_in),
    .serial_sample_out(sdo)
  );
  saso_audio_master saso_audio_master_inst (
    .lj_mode(format_select),
    .m_half(m_half),
    .sdo(sdo),
    .mclk(mclk),
    .bclk(bclk),
    .frame(frame),
    .left_word(left_word),
    .right_word(right_word),
    .frames(frames),
    .pad_errs(pad_errs)
  );
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  function automatic logic [23:0] dec_exp(input logic signed [saso_pkg::MOD_W-1:0] v,
                                          input int ratio);
    return 24'(int'(v) * ratio * 1024);
  endfunction
  function automatic logic [23:0] hp_next(input logic signed [23:0] y);
    return y - (y >>> 11);
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_frames(input int n);
    int f0;
    int t;
    f0 = frames;
    t = 0;
    while (frames < f0 + n && t < n * 3000)
    begin
      @(posedge clk_sys);
      t++;
    end
    if (t >= n * 3000)
    begin
      bad_count++;
      test_done();
    end
  endtask
  // modulator words move on master clock falling edges
  task automatic set_in(input logic [3:0] l, input logic [3:0] r);
    @(negedge mclk);
    left_analog_in = l;
    right_analog_in = r;
  endtask
  task automatic step(input logic bypass, input int m);
    @(posedge clk_sys);
    #1;
    highpass_bypass = bypass;
    m_half = m;
  endtask
  initial
  begin
    rst = 1'b1;
    format_select = 1'b0;
    highpass_bypass = 1'b0;
    left_analog_in = 4'h0;
    right_analog_in = 4'h0;
    m_half = 4;
    bad_count = 0;
    n_checks = 0;
    seed = $urandom(32'he5b4);
    // reset also spans several bit clock falls for the link side
    repeat (64) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      step(1'b1, ms[i]);
      format_select = i[0];
      lv = (i == 2) ? 4'h8 : 4'($urandom_range(15));
      rv = (i == 2) ? 4'h7 : 4'($urandom_range(15));
      set_in(lv, rv);
      wait_frames(4);
      p0 = pad_errs;
      wait_frames(2);
      check(left_word, dec_exp(lv, ms[i] * 64));
      check(right_word, dec_exp(rv, ms[i] * 64));
      check(24'(pad_errs - p0), 24'h0);
    end
    step(1'b0, 4);
    set_in(4'h3, 4'hb);
    wait_frames(5);
    w1l = left_word;
    w1r = right_word;
    wait_frames(1);
    check(left_word, hp_next(w1l));
    check(right_word, hp_next(w1r));
    step(1'b1, 5);
    wait_frames(3);
    w1l = left_word;
    w1r = right_word;
    set_in(4'h5, 4'ha);
    wait_frames(3);
    check(left_word, w1l);
    check(right_word, w1r);
    step(1'b1, 4);
    wait_frames(5);
    check(left_word, dec_exp(4'h5, 256));
    test_done();
  end
endmodule
